// File: rtc_map.svh
// register indexes, field positions, reset values and timing counts
// assumes byte address = 4 * index on a 32-bit register bus
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH
// register indexes
`define IDX_SEC    6'h10
`define IDX_MIN    6'h11
`define IDX_HOUR   6'h12
`define IDX_WDAY   6'h13
`define IDX_DAY    6'h14
`define IDX_MON    6'h15
`define IDX_YEAR   6'h16
`define IDX_RSV_A  6'h17
`define IDX_AL_MIN 6'h18
`define IDX_AL_HR  6'h19
`define IDX_AL_DAY 6'h1A
`define IDX_TMR_LO 6'h1B
`define IDX_TMR_HI 6'h1C
`define IDX_FSEL   6'h1D
`define IDX_FLAGS  6'h1E
`define IDX_CTRL   6'h1F
`define IDX_RAM_LO 6'h20
`define IDX_RAM_HI 6'h2F
`define IDX_RSV_B  6'h30
`define IDX_RSV_C  6'h31
`define IDX_IRQC   6'h32
// field positions
`define B_UF    5
`define B_TF    4
`define B_AF    3
`define B_VLF   1
`define B_STOP  6
`define B_UIE   5
`define B_TIE   4
`define B_AIE   3
`define B_TIMER_HALT  2
`define B_UPDATE_PERIOD_SELECT  5
`define B_TE    4
`define B_ALARM_DAY_MODE_SELECT  3
`define B_TIMER_IRQ_ROUTE 2
`define B_AE    7
// stored-bit masks; other bits read zero
`define M_SEC   8'h7F
`define M_HOUR  8'h3F
`define M_MON   8'h1F
`define M_FLAGS 8'h3A
`define M_CTRL  8'h7F
`define M_RSV_C 8'h1F
`define M_IRQC  8'h77
// reset value of the flag register: loss flag up
`define RST_FLAGS 8'h02
// timing
`define CLK_HZ  27'h2625A00
`define XTAL_HZ 17'h08000
`define RESP_OK 2'h0
`define RESP_ERR 2'h2
`endif

// File: rtc_pkg.sv
// types shared by the real-time clock register block
// assumes rtc_map.svh supplies the constants
package rtc_pkg;
  // pin drive levels, all registered
  typedef struct packed {
    logic clk_out;  // crystal-derived square wave
    logic one_oe;   // pulls interrupt pin one low
    logic two_oe;   // pulls interrupt pin two low
  } pins_t;
  // write channel handshake states
  typedef enum logic [2:0] {
    WR_IDLE = 3'b001,
    WR_PART = 3'b010,
    WR_RESP = 3'b100
  } wr_phase_t;
  // complete state of the block
  typedef struct packed {
    logic [7:0]       sec, min, hour, wday, day, mon, year, rsv_a;
    logic [7:0]       al_min, al_hr, al_day, tmr_lo, tmr_hi;
    logic [7:0]       fsel, flags, ctrl, rsv_b, rsv_c, irqc;
    logic [15:0][7:0] ram;
    logic [25:0]      acc;
    logic             half;
    logic [14:0]      pre;
    logic             pend;
    logic [15:0]      tmr_cnt;
    pins_t            pins;
    wr_phase_t        wph;
    logic             aw_held, w_held, wen;
    logic [5:0]       waddr;
    logic [7:0]       wdata, rdata;
    logic [1:0]       bresp, rresp;
    logic             rvalid;
  } state_t;
endpackage

// File: rtc_regs.sv
// real-time clock register bank, counters, alarm, timer and pin drive
// assumes an AXI4-Lite master on aclk, registers at byte address 4*index
// Function
// R01: update event sets flag, pulls pin one
// R02: supply drop sets oscillator loss flag
// R03: crystal-rate square wave on either pin
// R04: BCD time and calendar at consecutive offsets
// R05: alarm match registers with per-field enable
// R06: sixteen free user RAM bytes
// R07: 16-bit timer preset from two bytes
// R08: timer off, preset bytes act as RAM
// R09: two-bit rate select or inhibit output
// R10: update period per second or minute
// R11: write-prohibited bits ignored, read zero
// R12: marked alarm bits are free RAM
// R13: software writes fixed reserved setting data
// R14: power-on reset sets oscillator loss flag
// R15: software initialises after loss flag seen
// R16: software avoids invalid dates and times
// R17: test bits written zero, masked on read
// R18: halt freezes time, alarm, update events
// R19: halt stops slow timer sources
// R20: halt keeps only crystal-rate output
// R21: year multiple of four is leap
// R22: carries held during bus access
// R23: route picks pin for clock output
// R24: weekday one-hot, rotates once per day
// R25: flags stay until software writes zero
// R26: BCD fields masked, unused bits zero
`include "rtc_map.svh"
module rtc_regs #(
  parameter logic [16:0] XTAL_STEP = 17'(2 * `XTAL_HZ)  // half-period rate
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        supply_drop,
  output logic             clock_out_signal,
  output logic             irq_pin_one_o,
  output logic             irq_pin_one_oe,
  output logic             irq_pin_two_o,
  output logic             irq_pin_two_oe
);
  rtc_pkg::state_t s;         // registered state
  rtc_pkg::state_t n;         // next state
  logic [26:0]     acc_sum;   // accumulator plus step
  logic            xt_tick;   // one 32768 Hz tick
  logic            sec_tick;  // prescaler wrap
  logic            busy;      // bus access under way
  logic            halted;    // timekeeping stopped
  logic            step;      // apply held second carry
  logic            min_c;     // minute rolled over
  logic            hr_c;      // hour rolled over
  logic            day_c;     // day rolled over
  logic            leap;      // current year is leap
  logic [7:0]      dim;       // last day of month
  logic            al_hit;    // alarm fields all match
  logic            tsrc;      // timer source tick
  logic            tstop;     // timer count held
  logic            clk_lvl;   // selected output level
  logic            aw_have;   // address present
  logic            w_have;    // data present
  logic            wr_go;     // perform register write
  logic [5:0]      widx;      // write index
  logic [7:0]      wd;        // write byte
  logic            wstb;      // low byte lane enabled
  logic [7:0]      keep;      // flag write mask
  logic            uf_set;    // update event
  logic            tf_set;    // timer event
  logic            af_set;    // alarm event

  // decimal increment of a two-digit BCD byte
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  // register read value; unmapped and prohibited bits give zero
  function automatic logic [7:0] rd_val(input rtc_pkg::state_t q, input logic [5:0] i);
    rd_val = 8'h00;
    if (i >= `IDX_RAM_LO && i <= `IDX_RAM_HI) begin
      rd_val = q.ram[i[3:0]];
    end else begin
      unique case (i)
        `IDX_SEC:    rd_val = q.sec;
        `IDX_MIN:    rd_val = q.min;
        `IDX_HOUR:   rd_val = q.hour;
        `IDX_WDAY:   rd_val = q.wday;
        `IDX_DAY:    rd_val = q.day;
        `IDX_MON:    rd_val = q.mon;
        `IDX_YEAR:   rd_val = q.year;
        `IDX_RSV_A:  rd_val = q.rsv_a;
        `IDX_AL_MIN: rd_val = q.al_min;
        `IDX_AL_HR:  rd_val = q.al_hr;
        `IDX_AL_DAY: rd_val = q.al_day;
        `IDX_TMR_LO: rd_val = q.tmr_lo;
        `IDX_TMR_HI: rd_val = q.tmr_hi;
        `IDX_FSEL:   rd_val = q.fsel;
        `IDX_FLAGS:  rd_val = q.flags;
        `IDX_CTRL:   rd_val = q.ctrl;
        `IDX_RSV_B:  rd_val = q.rsv_b;
        `IDX_RSV_C:  rd_val = q.rsv_c;
        `IDX_IRQC:   rd_val = q.irqc;
        default:     rd_val = 8'h00;
      endcase
    end
  endfunction

  // mapped index window
  function automatic logic mapped(input logic [5:0] i);
    mapped = (i >= `IDX_SEC) && (i <= `IDX_IRQC);
  endfunction

  // handshake outputs straight from state
  assign awready = !s.aw_held && (s.wph != rtc_pkg::WR_RESP);
  assign wready  = !s.w_held && (s.wph != rtc_pkg::WR_RESP);
  assign bvalid  = (s.wph == rtc_pkg::WR_RESP);
  assign bresp   = s.bresp;
  assign arready = !s.rvalid;
  assign rvalid  = s.rvalid;
  assign rresp   = s.rresp;
  assign rdata   = {24'h000000, s.rdata};
  assign clock_out_signal = s.pins.clk_out;
  // open-drain pins only ever pull low
  assign irq_pin_one_o  = 1'b0;
  assign irq_pin_one_oe = s.pins.one_oe;
  assign irq_pin_two_o  = 1'b0;
  assign irq_pin_two_oe = s.pins.two_oe;

  // next-state logic for the whole block
  always_comb begin
    n = s;
    // crystal tick from a fractional accumulator on aclk
    acc_sum = {1'b0, s.acc} + {10'h000, XTAL_STEP};
    xt_tick = 1'b0;
    if (acc_sum >= `CLK_HZ) begin
      n.acc  = 26'(acc_sum - `CLK_HZ);
      n.half = !s.half;
      xt_tick = s.half;
    end else begin
      n.acc = acc_sum[25:0];
    end
    if (xt_tick) begin
      n.pre = s.pre + 15'h0001;
    end
    sec_tick = xt_tick && (s.pre == 15'h7FFF);
    halted   = s.ctrl[`B_STOP];
    busy     = awvalid || arvalid || s.aw_held || s.w_held
            || (s.wph == rtc_pkg::WR_RESP) || s.rvalid;
    // R22 hold carry during access
    if (sec_tick && !halted) begin
      n.pend = 1'b1;
    end
    // R18 halt freezes counting
    step  = s.pend && !busy && !halted;
    min_c = 1'b0;
    hr_c  = 1'b0;
    day_c = 1'b0;
    // R21 leap years by BCD digits
    leap = s.year[4] ? (s.year[3:0] == 4'h2 || s.year[3:0] == 4'h6)
                     : (s.year[3:0] == 4'h0 || s.year[3:0] == 4'h4 || s.year[3:0] == 4'h8);
    unique case (s.mon)
      8'h02:                      dim = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: dim = 8'h30;
      default:                    dim = 8'h31;
    endcase
    // R04 carry chain through BCD counters
    if (step) begin
      n.pend = sec_tick;
      n.sec  = (s.sec == 8'h59) ? 8'h00 : bcd_inc(s.sec);
      min_c  = (s.sec == 8'h59);
      if (min_c) begin
        n.min = (s.min == 8'h59) ? 8'h00 : bcd_inc(s.min);
        hr_c  = (s.min == 8'h59);
      end
      if (hr_c) begin
        n.hour = (s.hour == 8'h23) ? 8'h00 : bcd_inc(s.hour);
        day_c  = (s.hour == 8'h23);
      end
      if (day_c) begin
        // R24 one-hot weekday rotate
        n.wday = {1'b0, s.wday[5:0], s.wday[6]};
        n.day  = (s.day == dim) ? 8'h01 : bcd_inc(s.day);
        if (s.day == dim) begin
          n.mon = (s.mon == 8'h12) ? 8'h01 : bcd_inc(s.mon);
          if (s.mon == 8'h12) begin
            n.year = (s.year == 8'h99) ? 8'h00 : bcd_inc(s.year);
          end
        end
      end
    end
    // R10 update period choice
    uf_set = step && (s.fsel[`B_UPDATE_PERIOD_SELECT] ? min_c : 1'b1);
    // R05 alarm compare on each new minute; enable bit set drops the field
    al_hit = (s.al_min[`B_AE] || s.al_min[6:0] == n.min[6:0])
          && (s.al_hr[`B_AE] || s.al_hr[5:0] == n.hour[5:0])
          && (s.al_day[`B_AE] || (s.fsel[`B_ALARM_DAY_MODE_SELECT] ? (s.al_day[5:0] == n.day[5:0])
                                                  : ((s.al_day[6:0] & n.wday[6:0]) != 7'h00)));
    af_set = min_c && al_hit;
    // timer source taps: 4096 Hz, 64 Hz, 1 Hz, minute, hour
    unique case (s.fsel[2:0])
      3'h0:    tsrc = xt_tick && (s.pre[2:0] == 3'h7);
      3'h1:    tsrc = xt_tick && (s.pre[8:0] == 9'h1FF);
      3'h2:    tsrc = sec_tick;
      3'h3:    tsrc = step && min_c;
      3'h4:    tsrc = step && hr_c;
      default: tsrc = 1'b0;
    endcase
    // R19 halt holds the slow sources
    tstop  = s.ctrl[`B_TIMER_HALT] || (halted && s.fsel[2:0] != 3'h0);
    tf_set = 1'b0;
    // R07 reload from the 16-bit preset
    if (!s.fsel[`B_TE]) begin
      n.tmr_cnt = {s.tmr_hi, s.tmr_lo};
    end else if (tsrc && !tstop) begin
      if (s.tmr_cnt <= 16'h0001) begin
        tf_set    = 1'b1;
        n.tmr_cnt = {s.tmr_hi, s.tmr_lo};
      end else begin
        n.tmr_cnt = s.tmr_cnt - 16'h0001;
      end
    end
    // AXI write: address and data in either order
    aw_have = s.aw_held || (awvalid && awready);
    w_have  = s.w_held || (wvalid && wready);
    widx    = s.aw_held ? s.waddr : awaddr[7:2];
    wd      = s.w_held ? s.wdata : wdata[7:0];
    wstb    = s.w_held ? s.wen : wstrb[0];
    wr_go   = aw_have && w_have && (s.wph != rtc_pkg::WR_RESP);
    if (awvalid && awready) begin
      n.waddr = awaddr[7:2];
    end
    if (wvalid && wready) begin
      n.wdata = wdata[7:0];
      n.wen   = wstrb[0];
    end
    n.aw_held = aw_have && !wr_go;
    n.w_held  = w_have && !wr_go;
    unique case (s.wph)
      rtc_pkg::WR_IDLE, rtc_pkg::WR_PART: begin
        n.wph = wr_go ? rtc_pkg::WR_RESP
              : ((aw_have || w_have) ? rtc_pkg::WR_PART : rtc_pkg::WR_IDLE);
      end
      rtc_pkg::WR_RESP: begin
        n.wph = bready ? rtc_pkg::WR_IDLE : rtc_pkg::WR_RESP;
      end
      default: n.wph = rtc_pkg::WR_IDLE;
    endcase
    if (wr_go) begin
      n.bresp = mapped(widx) ? `RESP_OK : `RESP_ERR;
    end
    // register writes override counting in the same cycle
    keep = 8'hFF;
    if (wr_go && wstb) begin
      if (widx >= `IDX_RAM_LO && widx <= `IDX_RAM_HI) begin
        // R06 free user bytes
        n.ram[widx[3:0]] = wd;
      end else begin
        // R26 unused BCD bits forced to zero
        unique case (widx)
          `IDX_SEC: begin
            n.sec  = wd & `M_SEC;
            n.pre  = 15'h0000;  // sub-second chain restarts
            n.pend = 1'b0;
          end
          `IDX_MIN:    n.min  = wd & `M_SEC;
          `IDX_HOUR:   n.hour = wd & `M_HOUR;
          `IDX_WDAY:   n.wday = wd & `M_SEC;
          `IDX_DAY:    n.day  = wd & `M_HOUR;
          `IDX_MON:    n.mon  = wd & `M_MON;
          `IDX_YEAR:   n.year = wd;
          `IDX_RSV_A:  n.rsv_a = wd;
          `IDX_AL_MIN: n.al_min = wd;
          // R12 bit 6 kept as plain storage
          `IDX_AL_HR:  n.al_hr = wd;
          `IDX_AL_DAY: n.al_day = wd;
          // R08 preset bytes store freely
          `IDX_TMR_LO: n.tmr_lo = wd;
          `IDX_TMR_HI: n.tmr_hi = wd;
          `IDX_FSEL:   n.fsel = wd;
          `IDX_FLAGS:  keep = wd;
          // R17 test bit never stored
          `IDX_CTRL:   n.ctrl = wd & `M_CTRL;
          `IDX_RSV_B:  n.rsv_b = wd;
          // R11 prohibited bits dropped
          `IDX_RSV_C:  n.rsv_c = wd & `M_RSV_C;
          `IDX_IRQC:   n.irqc = wd & `M_IRQC;
          default:     keep = 8'hFF;
        endcase
      end
    end
    // R25 sticky flags, set beats a clearing write
    n.flags = (s.flags & keep & `M_FLAGS)
            | ({7'h00, uf_set} << `B_UF)
            | ({7'h00, tf_set} << `B_TF)
            | ({7'h00, af_set} << `B_AF)
            | ({7'h00, supply_drop} << `B_VLF);  // R02 loss flag
    // AXI read: one cycle to data, held until taken
    if (arvalid && arready) begin
      n.rvalid = 1'b1;
      n.rdata  = rd_val(s, araddr[7:2]);
      n.rresp  = mapped(araddr[7:2]) ? `RESP_OK : `RESP_ERR;
    end else if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    // R09 rate select; R20 only crystal rate while halted
    unique case (s.fsel[7:6])
      2'h0:    clk_lvl = s.half;
      2'h1:    clk_lvl = !halted && s.pre[4];
      2'h2:    clk_lvl = !halted && s.pre[14];
      default: clk_lvl = 1'b1;
    endcase
    n.pins.clk_out = clk_lvl && (s.fsel[7:6] != 2'h3);
    // R03 R23 route the clock to a pin, else events drive it
    // R01 update, alarm and routed timer events on pin one
    n.pins.one_oe = (s.irqc[1:0] == 2'h0) ? !clk_lvl
                  : ((s.flags[`B_UF] && s.ctrl[`B_UIE]) || (s.flags[`B_AF] && s.ctrl[`B_AIE])
                     || (s.flags[`B_TF] && s.ctrl[`B_TIE] && s.irqc[`B_TIMER_IRQ_ROUTE]));
    n.pins.two_oe = (s.irqc[1:0] == 2'h1) ? !clk_lvl
                  : (s.flags[`B_TF] && s.ctrl[`B_TIE] && !s.irqc[`B_TIMER_IRQ_ROUTE]);
  end

  // state register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s       <= '0;
      s.wph   <= rtc_pkg::WR_IDLE;
      // R14 power-on sets loss flag
      s.flags <= `RST_FLAGS;
    end else begin
      s <= n;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  vlf_after_reset_a: assert property ($rose(aresetn) |-> s.flags[`B_VLF]) // R14
    else $error("loss flag not set after reset");
  vlf_on_drop_a: assert property (supply_drop |=> s.flags[`B_VLF]) // R02
    else $error("supply drop did not set loss flag");
  halt_freeze_a: assert property (halted && !(wr_go && widx == `IDX_SEC) |=> $stable(s.sec)) // R18
    else $error("seconds moved while halted");
  busy_hold_a: assert property (busy |=> $stable(s.sec) || $past(wr_go)) // R22
    else $error("seconds moved during bus access");
  uf_sticky_a: assert property (s.flags[`B_UF] && !(wr_go && widx == `IDX_FLAGS) |=> s.flags[`B_UF]) // R25
    else $error("update flag dropped without write");
  update_irq_a: assert property (uf_set |=> s.flags[`B_UF]) // R01
    else $error("update event lost");
  wday_rot_a: assert property (day_c && !wr_go |=> s.wday == {1'b0, $past(s.wday[5:0]), $past(s.wday[6])}) // R24
    else $error("weekday did not rotate");
  clk_halt_a: assert property (halted && s.fsel[7:6] == 2'h2 |=> !s.pins.clk_out) // R20
    else $error("1 Hz output while halted");
  rdata_zero_a: assert property (rvalid |-> rdata[31:8] == 24'h000000 && !s.irqc[7] && !s.irqc[3]) // R11
    else $error("upper read bits not zero");
  bresp_next_a: assert property (wr_go |=> bvalid ##0 bvalid[*1]) // write response on the next cycle
    else $error("write response missing");
  timer_off_a: assert property (!s.fsel[`B_TE] |-> !tf_set) // R08
    else $error("timer event while disabled");

  write_done_c: cover property (wr_go ##1 bvalid && bready);
  read_done_c: cover property (rvalid && rready);
  alarm_hit_c: cover property (af_set);
  timer_hit_c: cover property (tf_set);
endmodule

// File: rtc_host.sv
// host model: AXI4-Lite master that stands in for software
// assumes aclk from the bench and one write or one read at a time
module rtc_host (
  input  wire logic        aclk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic        rvalid,
  output logic             rready
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idle from time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // one write: address and data offered together, held until taken
  task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic st);
    @(posedge aclk);
    awaddr  <= {idx, 2'h0};
    awvalid <= 1'b1;
    // upper bits and upper strobes always sent as zero
    wdata   <= {24'h000000, d};
    wstrb   <= {3'h0, st};
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      // released address and data show their inverse, never the stale value
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr  <= ~awaddr;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata  <= ~wdata;
      end
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  // one read, ready held until the answer is seen
  task automatic rd(input logic [5:0] idx);
    @(posedge aclk);
    araddr  <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr  <= ~araddr;
      end
    end while (!rvalid);
    rready <= 1'b0;
  endtask
endmodule

// File: rtc_register_map_control_tb.sv
// self-checking bench for the clock register block
// assumes rtc_map.svh and a sped-up crystal via XTAL_STEP
`include "rtc_map.svh"
module rtc_register_map_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, supply_drop;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        clock_out_signal, irq_pin_one_o, irq_pin_one_oe;
  logic        irq_pin_two_o, irq_pin_two_oe;
  int          n_mismatch, n_tests, seed;
  logic [33:0] qr[$];  // expected {rresp, rdata}
  logic [1:0]  qb[$];  // expected bresp
  logic [7:0]  mem[16];
  // interrupt pins are open drain with a pull-up
  wire pin_one = irq_pin_one_oe ? irq_pin_one_o : 1'b1;
  wire pin_two = irq_pin_two_oe ? irq_pin_two_o : 1'b1;
  // reserved setting data, a valid date and time, then timer off with the crystal-rate clock on pin one
  localparam logic [15:0] INIT_T [13] = '{16'h17D8, 16'h3000, 16'h3108, 16'h3200, 16'h1000, 16'h1100,
    16'h1200, 16'h1301, 16'h1401, 16'h1501, 16'h1600, 16'h1F00, 16'h1D00};
  // index and stored-bit mask
  localparam logic [15:0] MASK_T [14] = '{16'h107F, 16'h117F, 16'h123F, 16'h137F, 16'h143F, 16'h151F,
    16'h16FF, 16'h18FF, 16'h19FF, 16'h1AFF, 16'h1BFF, 16'h1CFF, 16'h311F, 16'h3277};
  // rate select, route, control, expected {clock, pin one, pin two} activity
  localparam logic [31:0] CLK_T [7] = '{32'h00000006, 32'h00010005, 32'h00020004, 32'hC0000000,
    32'h00004006, 32'h40000006, 32'h40004000};
  // 25 ns clock
  initial aclk = 1'b0;
  always #12.5 aclk = ~aclk;
  // crystal sped up so a 1024 Hz half period is about 10k cycles
  rtc_regs #(.XTAL_STEP(17'h1FFFF)) rtc_regs_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .supply_drop, .clock_out_signal, .irq_pin_one_o, .irq_pin_one_oe, .irq_pin_two_o,
    .irq_pin_two_oe);
  rtc_host rtc_host_inst (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rvalid, .rready);
  // single compare point
  task automatic check(input string nm, input logic [33:0] exp, input logic [33:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // verdict and end of run
  task automatic results();
    if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // note the response, then drive the write
  task automatic bw(input logic [5:0] i, input logic [7:0] d, input logic st, input logic [1:0] r);
    qb.push_back(r);
    rtc_host_inst.wr(i, d, st);
  endtask
  // note the read result, then drive the read
  task automatic br(input logic [5:0] i, input logic [7:0] d, input logic [1:0] r);
    qr.push_back({r, 24'h000000, d});
    rtc_host_inst.rd(i);
  endtask
  // software initialisation after the loss flag was seen
  task automatic init_regs();
    // setting data, valid time, test bit zero
    foreach (INIT_T[i]) bw(INIT_T[i][13:8], INIT_T[i][7:0], 1'b1, `RESP_OK);
  endtask
  // watch for any level change on clock and both pins
  task automatic watch(input int n, input logic [2:0] exp);
    logic [2:0] prev, seen;
    prev = {clock_out_signal, pin_one, pin_two};
    seen = 3'h0;
    repeat (n) begin
      @(posedge aclk);
      seen = seen | (prev ^ {clock_out_signal, pin_one, pin_two});
      prev = {clock_out_signal, pin_one, pin_two};
    end
    check("activity", {31'h0, exp}, {31'h0, seen});
  endtask
  // responses compared with the oldest note as they appear
  always @(posedge aclk) begin
    if (bvalid && bready) check("bresp", {32'h0, qb.pop_front()}, {32'h0, bresp});
    if (rvalid && rready) check("rdata", qr.pop_front(), {rresp, rdata});
  end
  // hang guard, well beyond the expected 60k cycles
  initial begin
    repeat (90000) @(posedge aclk);
    n_mismatch++;
    results();
  end
  // main sequence
  initial begin
    logic [7:0] v;
    logic       st;
    seed = $urandom(32'hC7863E77);
    n_mismatch = 0;
    n_tests = 0;
    aresetn = 1'b0;
    supply_drop = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    br(`IDX_FLAGS, `RST_FLAGS, `RESP_OK);
    init_regs();
    br(`IDX_RSV_C, 8'h08, `RESP_OK);
    // writing ones keeps flags and cannot set them
    bw(`IDX_FLAGS, 8'hFF, 1'b1, `RESP_OK);
    br(`IDX_FLAGS, 8'h02, `RESP_OK);
    bw(`IDX_FLAGS, 8'h00, 1'b1, `RESP_OK);
    br(`IDX_FLAGS, 8'h00, `RESP_OK);
    supply_drop <= 1'b1;
    @(posedge aclk);
    supply_drop <= 1'b0;
    br(`IDX_FLAGS, 8'h02, `RESP_OK);
    br(`IDX_FLAGS, 8'h02, `RESP_OK);
    // random data through every masked register but control and flags, timer off
    foreach (MASK_T[i]) begin
      v = 8'($urandom);
      bw(MASK_T[i][13:8], v, 1'b1, `RESP_OK);
      br(MASK_T[i][13:8], v & MASK_T[i][7:0], `RESP_OK);
    end
    bw(`IDX_CTRL, 8'h7F, 1'b1, `RESP_OK);
    br(`IDX_CTRL, 8'h7F, `RESP_OK);
    init_regs();
    // user bytes: full pass, then a pass with random strobes
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 16; i++) begin
        v = 8'($urandom);
        st = (p == 0) ? 1'b1 : 1'($urandom);
        bw(`IDX_RAM_LO + 6'(i), v, st, `RESP_OK);
        if (st) mem[i] = v;
      end
    end
    for (int i = 0; i < 16; i++) br(`IDX_RAM_LO + 6'(i), mem[i], `RESP_OK);
    // unmapped places answer with an error
    bw(6'h0F, 8'hA5, 1'b1, `RESP_ERR);
    br(6'h0F, 8'h00, `RESP_ERR);
    br(6'h33, 8'h00, `RESP_ERR);
    // rate, route and halt combinations on the clock output
    foreach (CLK_T[i]) begin
      bw(`IDX_FSEL, CLK_T[i][31:24], 1'b1, `RESP_OK);
      bw(`IDX_IRQC, CLK_T[i][23:16], 1'b1, `RESP_OK);
      bw(`IDX_CTRL, CLK_T[i][15:8], 1'b1, `RESP_OK);
      watch((CLK_T[i][31:24] == 8'h40) ? 22000 : 800, CLK_T[i][2:0]);
    end
    // timer: preset 2 on the 4096 Hz tap, event routed to pin two
    bw(`IDX_TMR_LO, 8'h02, 1'b1, `RESP_OK);
    bw(`IDX_TMR_HI, 8'h00, 1'b1, `RESP_OK);
    bw(`IDX_IRQC, 8'h02, 1'b1, `RESP_OK);
    bw(`IDX_CTRL, 8'h10, 1'b1, `RESP_OK);
    bw(`IDX_FSEL, 8'h10, 1'b1, `RESP_OK);
    // taps are about 4.9k cycles apart, so two arrive within about 9.8k cycles
    repeat (12000) @(posedge aclk);
    check("pin_two", 34'h0, {33'h0, pin_two});
    br(`IDX_FLAGS, 8'h12, `RESP_OK);
    results();
  end
endmodule
